/* src/gfs_pkg.sv */
// Contract
// - Summary register at offset 0h, read only, reset value C0h.
// - Summary bit 7 low after any serial clock count fault; reset high.
// - Summary bit 6 high on power-on-reset detection; set after reset.
// - Summary bit 5 always mirrors the fault output pin state.
// - Summary bit 3 is OR of all overcurrent and gate fault flags.
// - Summary bit 0 ORs thermal, watchdog, direction, precharge, predischarge, slew warnings.
// - Offset 1h holds eight overcurrent flags, one per MOSFET, reset 0.
// - Flag order from bit 7: high 1, low 1, high 2, ... low 4.
// - Offset 3h holds eight gate fault flags, same order, reset 0.
// - Detail register 5h: supply low b7, supply high b6, pump low b5.
// - Detail bit 4 thermal warning, bit 3 thermal shutdown.
// - Detail bit 2 reports watchdog expiry.
// - Detail bit 1 set when a frame has other than 16 clocks.
// - Serial clock count fault never drives fault pin or its summary bit.
`default_nettype none
package gfs_pkg;
  localparam int          ADDR_W           = 6;
  localparam int          DATA_W           = 8;
  localparam logic [5:0]  OFS_SUMMARY      = 6'h00;
  localparam logic [5:0]  OFS_OVERCURRENT  = 6'h01;
  localparam logic [5:0]  OFS_GATE         = 6'h03;
  localparam logic [5:0]  OFS_DETAIL       = 6'h05;
  localparam logic [7:0]  RST_SUMMARY      = 8'hC0;
  localparam logic [7:0]  RST_FLAGS        = 8'h00;
  localparam int          SUM_SERIAL_OK    = 7;
  localparam int          SUM_POR          = 6;
  localparam int          SUM_FAULT        = 5;
  localparam int          SUM_WARN         = 4;
  localparam int          SUM_MOSFET       = 3;
  localparam int          SUM_SUPPLY_LOW   = 2;
  localparam int          SUM_SUPPLY_HIGH  = 1;
  localparam int          SUM_THERMAL_WD   = 0;
  localparam int          DET_SUPPLY_LOW   = 7;
  localparam int          DET_SUPPLY_HIGH  = 6;
  localparam int          DET_PUMP_LOW     = 5;
  localparam int          DET_THERM_WARN   = 4;
  localparam int          DET_THERM_SHUT   = 3;
  localparam int          DET_WATCHDOG     = 2;
  localparam int          DET_SCLK_ERR     = 1;
  localparam logic [4:0]  FRAME_CLOCKS     = 5'd16;
endpackage
`default_nettype wire

/* src/gfs_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module gfs_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         sys_rst,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] stage1;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      stage1   <= '0;
      sync_out <= '0;
    end else begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end
endmodule // gfs_sync
`default_nettype wire

/* src/gfs_frame_check.sv */
`timescale 1ns/1ps
`default_nettype none
module gfs_frame_check
  import gfs_pkg::*;
(
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic frame_active,
  input  wire logic sclk_level,
  output logic      count_error
);
  logic       sclk_prev;
  logic       active_prev;
  logic [5:0] pulses;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sclk_prev   <= 1'b0;
      active_prev <= 1'b0;
      pulses      <= 6'h00;
      count_error <= 1'b0;
    end else begin
      sclk_prev   <= sclk_level;
      active_prev <= frame_active;
      count_error <= 1'b0;
      if (frame_active && !active_prev)
        pulses <= 6'h00;
      else if (frame_active && sclk_level && !sclk_prev && pulses != 6'h3F)
        pulses <= pulses + 6'h01;
      // Judged once, at the end of the frame
      if (!frame_active && active_prev)
        count_error <= (pulses != {1'b0, FRAME_CLOCKS});
    end
  end
endmodule // gfs_frame_check
`default_nettype wire

/* src/gfs_status_regs.sv */
`timescale 1ns/1ps
`default_nettype none
module gfs_status_regs (
  input  wire logic                   clk,
  input  wire logic                   sys_rst,
  input  wire logic [gfs_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic                   reg_rd,
  input  wire logic                   reg_wr,
  input  wire logic [gfs_pkg::DATA_W-1:0] reg_wdata,
  output logic      [gfs_pkg::DATA_W-1:0] reg_rdata,
  input  wire logic                   frame_active,
  input  wire logic                   sclk_level,
  input  wire logic                   clear_faults,
  input  wire logic                   por_clear,
  input  wire logic [7:0]             overcurrent_in,
  input  wire logic [7:0]             gate_fault_in,
  input  wire logic                   power_supply_low,
  input  wire logic                   power_supply_high,
  input  wire logic                   charge_pump_low,
  input  wire logic                   thermal_warning,
  input  wire logic                   thermal_shutdown,
  input  wire logic                   watchdog_expired,
  input  wire logic                   current_direction_unknown,
  input  wire logic                   precharge_range_warning,
  input  wire logic                   predischarge_range_warning,
  input  wire logic                   slew_time_overflow,
  input  wire logic                   warning_in,
  output logic                        fault_output_pin_n
);
  import gfs_pkg::*;

  // ==========================================================
  // Input synchronisation
  // ==========================================================
  // Four frame and control levels, sixteen MOSFET flags, eleven monitor levels
  localparam int MON_W = 31;
  logic [MON_W-1:0] mon_raw;
  logic [MON_W-1:0] mon;
  logic             frame_s;
  logic             sclk_s;
  logic             clear_s;
  logic             por_clear_s;
  logic [7:0]       oc_s;
  logic [7:0]       gf_s;
  logic             psl_s, psh_s, cpl_s, tw_s, ts_s, wd_s;
  logic             cdu_s, pcr_s, pdr_s, sto_s, warn_s;

  assign mon_raw = {frame_active, sclk_level, clear_faults, por_clear,
                    overcurrent_in, gate_fault_in,
                    power_supply_low, power_supply_high, charge_pump_low,
                    thermal_warning, thermal_shutdown, watchdog_expired,
                    current_direction_unknown, precharge_range_warning,
                    predischarge_range_warning, slew_time_overflow, warning_in};

  gfs_sync #(.W(MON_W)) u_sync (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .async_in (mon_raw),
    .sync_out (mon)
  );

  assign {frame_s, sclk_s, clear_s, por_clear_s, oc_s, gf_s,
          psl_s, psh_s, cpl_s, tw_s, ts_s, wd_s,
          cdu_s, pcr_s, pdr_s, sto_s, warn_s} = mon;

  // ==========================================================
  // Serial frame clock counting
  // ==========================================================
  logic sclk_error_event;

  gfs_frame_check u_frame (
    .clk          (clk),
    .sys_rst      (sys_rst),
    .frame_active (frame_s),
    .sclk_level   (sclk_s),
    .count_error  (sclk_error_event)
  );

  // ==========================================================
  // Latched fault flags
  // ==========================================================
  // Flags are sticky; a new event in the clearing cycle wins.
  logic [7:0] overcurrent_flags;
  logic [7:0] gate_flags;
  logic [7:0] detail_flags;
  logic       serial_fault_seen;
  logic       por_flag;
  logic [7:0] detail_now;
  logic       other_warn;

  assign detail_now = {psl_s, psh_s, cpl_s, tw_s, ts_s, wd_s, sclk_error_event, 1'b0};

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      overcurrent_flags <= RST_FLAGS;
      gate_flags        <= RST_FLAGS;
    end else begin
      // Bit 7 is high side 1, bit 0 low side 4, as wired by the caller
      overcurrent_flags <= (clear_s ? 8'h00 : overcurrent_flags) | oc_s;
      gate_flags        <= (clear_s ? 8'h00 : gate_flags) | gf_s;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst)
      detail_flags <= RST_FLAGS;
    else
      detail_flags <= (clear_s ? 8'h00 : detail_flags) | detail_now;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      serial_fault_seen <= 1'b0;
      por_flag          <= 1'b1;
    end else begin
      serial_fault_seen <= (clear_s ? 1'b0 : serial_fault_seen) | sclk_error_event;
      if (por_clear_s)
        por_flag <= 1'b0;
    end
  end

  // ==========================================================
  // Summary and fault pin
  // ==========================================================
  logic [7:0] summary;
  logic       fault_state;

  assign other_warn = cdu_s | pcr_s | pdr_s | sto_s;
  // Serial clock errors are kept out of the pin
  assign fault_state = |overcurrent_flags | |gate_flags |
                       (|detail_flags[DET_SUPPLY_LOW:DET_WATCHDOG]);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      summary            <= RST_SUMMARY;
      fault_output_pin_n <= 1'b1;
    end else begin
      summary[SUM_SERIAL_OK]   <= ~(serial_fault_seen | sclk_error_event);
      summary[SUM_POR]         <= por_flag & ~por_clear_s;
      summary[SUM_FAULT]       <= fault_state;
      summary[SUM_WARN]        <= warn_s;
      summary[SUM_MOSFET]      <= |overcurrent_flags | |gate_flags;
      summary[SUM_SUPPLY_LOW]  <= detail_flags[DET_SUPPLY_LOW] | detail_flags[DET_PUMP_LOW];
      summary[SUM_SUPPLY_HIGH] <= detail_flags[DET_SUPPLY_HIGH];
      summary[SUM_THERMAL_WD]  <= detail_flags[DET_THERM_WARN] | detail_flags[DET_THERM_SHUT] |
                                  detail_flags[DET_WATCHDOG] | other_warn;
      // Same register timing as the summary bit so both agree every cycle
      fault_output_pin_n       <= ~fault_state;
    end
  end

  // ==========================================================
  // Register read port
  // ==========================================================
  // Writes are accepted and dropped: every location here is read only.
  logic       unused_wr;
  assign unused_wr = reg_wr ^ (^reg_wdata);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      unique case (reg_addr)
        OFS_SUMMARY:     reg_rdata <= summary;
        OFS_OVERCURRENT: reg_rdata <= overcurrent_flags;
        OFS_GATE:        reg_rdata <= gate_flags;
        OFS_DETAIL:      reg_rdata <= {detail_flags[7:1], 1'b0};
        default:         reg_rdata <= 8'h00;
      endcase
    end
  end
endmodule // gfs_status_regs
`default_nettype wire

/* bench/gfs_props.sv */
`timescale 1ns/1ps
`default_nettype none
// ========
// Status bank port checks
module gfs_props (
  input wire logic       clk,
  input wire logic       sys_rst,
  input wire logic [5:0] reg_addr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic [7:0] overcurrent_in,
  input wire logic [7:0] gate_fault_in,
  input wire logic       fault_output_pin_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  property p_unmap; reg_rd && !(reg_addr inside {6'h00, 6'h01, 6'h03, 6'h05}) |=> reg_rdata == 8'h00; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_hold; !reg_rd |=> $stable(reg_rdata); endproperty
  a_hold: assert property (p_hold) else $error("read data moved without read");
  property p_det0; reg_rd && reg_addr == 6'h05 |=> !reg_rdata[0]; endproperty
  a_det0: assert property (p_det0) else $error("detail bit 0 set");
  property p_mirror; reg_rd && reg_addr == 6'h00 |=> reg_rdata[5] == !$past(fault_output_pin_n); endproperty
  a_mirror: assert property (p_mirror) else $error("summary fault bit differs from pin");
  property p_rst; $fell(sys_rst) |-> fault_output_pin_n && reg_rdata == 8'h00; endproperty
  a_rst: assert property (p_rst) else $error("bad state after reset");
  // Six samples cover the two-flop sync plus flag and pin stages
  property p_oc_pin; (overcurrent_in != 8'h00) [*6] |-> !fault_output_pin_n; endproperty
  a_oc_pin: assert property (p_oc_pin) else $error("overcurrent did not pull pin");
  property p_oc_ord; $stable(overcurrent_in) [*6] ##0 (reg_rd && reg_addr == 6'h01)
    |=> (reg_rdata & $past(overcurrent_in)) == $past(overcurrent_in); endproperty
  a_oc_ord: assert property (p_oc_ord) else $error("overcurrent flag missing");
  property p_gf_ord; $stable(gate_fault_in) [*6] ##0 (reg_rd && reg_addr == 6'h03)
    |=> (reg_rdata & $past(gate_fault_in)) == $past(gate_fault_in); endproperty
  a_gf_ord: assert property (p_gf_ord) else $error("gate fault flag missing");
  c_sum: cover property (reg_rd && reg_addr == 6'h00);
  c_pin: cover property ($fell(fault_output_pin_n));
  c_unmap: cover property (reg_rd && reg_addr == 6'h02);
endmodule // gfs_props
`default_nettype wire

/* bench/gfs_spi_host.sv */
`timescale 1ns/1ps
`default_nettype none
// ========
// Serial host: one frame per go pulse, clock idles low between frames
module gfs_spi_host (
  input  wire logic       clk,
  input  wire logic       go,
  input  wire logic [5:0] pulses,
  output logic            frame_active,
  output logic            sclk_level
);
  initial begin
    frame_active = 1'b0;
    sclk_level   = 1'b0;
  end
  always @(posedge go) begin
    frame_active <= 1'b1;
    repeat (4) @(posedge clk);
    // Slow edges: each level lasts longer than the two-flop sync
    for (int k = 0; k < pulses; k++) begin
      sclk_level <= 1'b1;
      repeat (3) @(posedge clk);
      sclk_level <= 1'b0;
      repeat (3) @(posedge clk);
    end
    frame_active <= 1'b0;
  end
endmodule // gfs_spi_host
`default_nettype wire

/* bench/gfs_status_regs_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
// ========
// Bench top
module gfs_status_regs_tb_top;
  logic       clk, sys_rst, reg_rd, reg_wr, clear_faults, por_clear, frame_active, sclk_level, go;
  logic       fault_output_pin_n;
  logic [5:0] reg_addr, np;
  logic [7:0] reg_wdata, reg_rdata, overcurrent_in, gate_fault_in;
  logic [10:0] m;
  int         n_fail, n_compared, cyc;
  gfs_status_regs dut (.clk, .sys_rst, .reg_addr, .reg_rd, .reg_wr, .reg_wdata, .reg_rdata, .frame_active,
    .sclk_level, .clear_faults, .por_clear, .overcurrent_in, .gate_fault_in, .power_supply_low(m[9]),
    .power_supply_high(m[8]), .charge_pump_low(m[7]), .thermal_warning(m[6]), .thermal_shutdown(m[5]),
    .watchdog_expired(m[4]), .current_direction_unknown(m[3]), .precharge_range_warning(m[2]),
    .predischarge_range_warning(m[1]), .slew_time_overflow(m[0]), .warning_in(m[10]), .fault_output_pin_n);
  gfs_spi_host host (.clk, .go, .pulses(np), .frame_active, .sclk_level);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ========
  // Shared tasks
  task automatic final_report();
    if (n_fail == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 4000) begin
      n_fail++;
      final_report();
    end
  end
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [5:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    // Read data stands until the next read, so it is taken one edge later
    @(posedge clk);
    cmp(reg_rdata, exp);
  endtask
  task automatic clr();
    clear_faults <= 1'b1;
    repeat (6) @(posedge clk);
    clear_faults <= 1'b0;
    repeat (6) @(posedge clk);
  endtask
  task automatic frame(input logic [5:0] n);
    np <= n;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    repeat (6 * n + 20) @(posedge clk);
  endtask
  // ========
  // Scenarios
  task automatic t_reset();
    rd(6'h00, 8'hC0);
    rd(6'h01, 8'h00);
    rd(6'h03, 8'h00);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= 6'h00;
    reg_wdata <= 8'h3F;
    @(posedge clk);
    reg_wr <= 1'b0;
    rd(6'h02, 8'h00);
    rd(6'h00, 8'hC0);
    rd(6'h05, 8'h00);
  endtask
  task automatic t_mosfet(input bit g);
    for (int i = 0; i < 8; i++) begin
      if (g) gate_fault_in <= 8'h01 << i;
      else overcurrent_in <= 8'h01 << i;
      repeat (6) @(posedge clk);
      rd(6'h00, 8'hE8);
      rd(g ? 6'h03 : 6'h01, 8'h01 << i);
      cmp({7'h00, fault_output_pin_n}, 8'h00);
      gate_fault_in  <= 8'h00;
      overcurrent_in <= 8'h00;
      clr();
    end
  endtask
  task automatic t_detail();
    logic [7:0] e;
    for (int i = 0; i < 11; i++) begin
      m <= 11'h001 << i;
      repeat (6) @(posedge clk);
      e = 8'hC0 | ((i >= 4 && i <= 9) ? 8'h20 : 8'h00) | (i <= 6 ? 8'h01 : 8'h00);
      e = e | (i == 9 || i == 7 ? 8'h04 : 8'h00) | (i == 8 ? 8'h02 : 8'h00) | (i == 10 ? 8'h10 : 8'h00);
      rd(6'h00, e);
      rd(6'h05, (i >= 4 && i <= 9) ? 8'h01 << (i - 2) : 8'h00);
      m <= 11'h000;
      clr();
    end
  endtask
  task automatic t_frame();
    frame(6'd16);
    rd(6'h00, 8'hC0);
    rd(6'h05, 8'h00);
    frame(6'd15);
    rd(6'h00, 8'h40);
    rd(6'h05, 8'h02);
    cmp({7'h00, fault_output_pin_n}, 8'h01);
    por_clear <= 1'b1;
    repeat (6) @(posedge clk);
    por_clear <= 1'b0;
    rd(6'h00, 8'h00);
    clr();
    rd(6'h00, 8'h80);
  endtask
  initial begin
    {sys_rst, reg_rd, reg_wr, clear_faults, por_clear, go} = 6'b100000;
    {reg_addr, np, reg_wdata, overcurrent_in, gate_fault_in, m} = '0;
    {n_fail, n_compared, cyc} = '0;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    t_reset();
    t_mosfet(1'b0);
    t_mosfet(1'b1);
    t_detail();
    t_frame();
    final_report();
  end
endmodule // gfs_status_regs_tb_top
bind gfs_status_regs gfs_props chk (.clk, .sys_rst, .reg_addr, .reg_rd, .reg_rdata, .overcurrent_in,
  .gate_fault_in, .fault_output_pin_n);
`default_nettype wire
